// [rtl/jdt_pkg.sv]
// Shared constants and types of the test access and trace port
package jdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register
  localparam int IR_LEN = 4;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // Data register width
  localparam int DR_LEN = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Trace status codes
  localparam logic [2:0] TS_STALL = 3'h7;
  localparam logic [2:0] TS_JUMP_PC = 3'h6;
  localparam logic [2:0] TS_JUMP_NOPC = 3'h5;
  localparam logic [2:0] TS_EXCEPT = 3'h4;
  localparam logic [2:0] TS_SEQ = 3'h3;
  localparam logic [2:0] TS_TRACE_STALL = 3'h2;
  localparam logic [2:0] TS_TRIGGER = 3'h1;
  localparam logic [2:0] TS_DEBUG = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Trace word path
  localparam int PC_W = 32;
  localparam int FIFO_W = 35;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] PC_LAST_BIT = 5'h1f;

  // Trace clock half periods in system clocks less one, full and divided rate
  localparam logic [1:0] TC_HALF_FULL = 2'h0;
  localparam logic [1:0] TC_HALF_DIV = 2'h1;

  // Reset values
  localparam logic [DR_LEN-1:0] DR_RESET = 32'h0;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Test access controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } jdt_tap_t;

endpackage

// [rtl/jdt_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
// Word FIFO with registered full and empty flags
module jdt_fifo #(
  parameter int W = 35,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic inRdy;
    logic outVld;
  } jdt_fifo_st_t;

  jdt_fifo_st_t s_r;
  jdt_fifo_st_t s_nxt;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer, count and flag update
  always_comb
  begin
    s_nxt = s_r;
    push = inValid && s_r.inRdy;
    pop = outReady && s_r.outVld;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = inData;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = s_r.rp + 1'b1;
    if (push && !pop)
      s_nxt.cnt = s_r.cnt + 1'b1;
    else if (pop && !push)
      s_nxt.cnt = s_r.cnt - 1'b1;
    s_nxt.inRdy = s_nxt.cnt != FULL_CNT;
    s_nxt.outVld = s_nxt.cnt != '0;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_r <= s_nxt;
      s_r.wp <= '0;
      s_r.rp <= '0;
      s_r.cnt <= '0;
      s_r.inRdy <= 1'b0;
      s_r.outVld <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  assign inReady = s_r.inRdy;
  assign outValid = s_r.outVld;
  assign outData = s_r.mem[s_r.rp];
endmodule
`default_nettype wire

// [rtl/jdt_port.sv]
`timescale 1ns/10ps
`default_nettype none
module jdt_port #(
  parameter logic [31:0] ID_CODE = 32'h0000_0001 // Arbitrary identity value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tckPin,
  input wire logic tmsPin,
  input wire logic tdiPin,
  input wire logic trstPinN,
  output logic tdoOut,
  output logic tdoOe,
  input wire logic traceMode,
  input wire logic debugMode,
  input wire logic traceDiv,
  input wire logic pcValid,
  input wire logic [jdt_pkg::PC_W-1:0] pcData,
  input wire logic [2:0] pcStatus,
  output logic pcReady,
  output logic traceClk,
  output logic [2:0] traceStatus,
  output logic traceRunning,
  output logic dbgIntReq
);
  import jdt_pkg::*;

  typedef struct packed {
    logic [1:0] tckSy;
    logic [1:0] tmsSy;
    logic [1:0] tdiSy;
    logic [1:0] trstSy;
    logic tckPrev;
    jdt_tap_t tap;
    logic [IR_LEN-1:0] ir;
    logic [IR_LEN-1:0] irSh;
    logic [DR_LEN-1:0] drSh;
    logic jtdo;
    logic joe;
    logic [1:0] divCnt;
    logic tClk;
    logic [PC_W-1:0] word;
    logic [4:0] bitCnt;
    logic busy;
    logic tBit;
    logic pop;
    logic [2:0] status;
    logic rtActive;
    logic dint;
    logic tdo;
    logic oe;
  } jdt_port_st_t;

  // Registered state and its next value
  jdt_port_st_t s_r;
  jdt_port_st_t s_nxt;

  // Strobes decoded from the registered pins
  logic tckRise;
  logic tckFall;
  logic tapRst;
  logic trOn;
  logic tcFall;

  // Handshake with the trace word buffer
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic [FIFO_W-1:0] fifoOut;

  ////////////////////////////////////////////////////////////////////////////
  // Controller next state from mode select
  function automatic jdt_tap_t tapNext(input jdt_tap_t st, input logic tms);
    jdt_tap_t nx;
    nx = st;
    unique case (st)
      TAP_RESET: nx = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nx = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nx = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: nx = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: nx = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: nx = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: nx = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nx = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: nx = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: nx = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: nx = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: nx = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: nx = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
    return nx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Edge and event decode from synchronised pins
  always_comb
  begin
    tckRise = s_r.tckSy[1] && !s_r.tckPrev;
    tckFall = !s_r.tckSy[1] && s_r.tckPrev;
    tapRst = !s_r.trstSy[1];
    trOn = traceMode && s_r.rtActive;
    tcFall = trOn && s_r.tClk && (s_r.divCnt == (traceDiv ? TC_HALF_DIV : TC_HALF_FULL));
    fifoInValid = trOn && pcValid && (pcStatus == TS_JUMP_PC || pcStatus == TS_EXCEPT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Whole next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pop = 1'b0;
    // Two-stage synchronisers for every pin
    s_nxt.tckSy = {s_r.tckSy[0], tckPin};
    s_nxt.tmsSy = {s_r.tmsSy[0], tmsPin};
    s_nxt.tdiSy = {s_r.tdiSy[0], tdiPin};
    s_nxt.trstSy = {s_r.trstSy[0], trstPinN};
    s_nxt.tckPrev = s_r.tckSy[1];

    // Test access controller
    if (tapRst)
    begin
      s_nxt.tap = TAP_RESET;
      s_nxt.ir = IR_IDCODE;
      s_nxt.joe = 1'b0;
    end
    else if (tckRise)
    begin
      // Capture, shift and update by controller state
      unique case (s_r.tap)
        TAP_RESET: s_nxt.ir = IR_IDCODE;
        TAP_CAP_DR: s_nxt.drSh = (s_r.ir == IR_IDCODE) ? ID_CODE : DR_RESET;
        TAP_SH_DR:
        begin
          if (s_r.ir == IR_IDCODE)
            s_nxt.drSh = {s_r.tdiSy[1], s_r.drSh[DR_LEN-1:1]};
          else
            s_nxt.drSh[0] = s_r.tdiSy[1];
        end
        TAP_CAP_IR: s_nxt.irSh = IR_CAPTURE;
        TAP_SH_IR: s_nxt.irSh = {s_r.tdiSy[1], s_r.irSh[IR_LEN-1:1]};
        TAP_UPD_IR:
        begin
          // Unknown codes fall back to the one-bit path
          if (s_r.irSh == IR_IDCODE)
            s_nxt.ir = IR_IDCODE;
          else
            s_nxt.ir = IR_BYPASS;
        end
        default: s_nxt.ir = s_r.ir;
      endcase
      s_nxt.tap = tapNext(s_r.tap, s_r.tmsSy[1]);
    end
    else if (tckFall)
    begin
      // Output side moves while the test clock is low
      s_nxt.joe = (s_r.tap == TAP_SH_IR) || (s_r.tap == TAP_SH_DR);
      s_nxt.jtdo = (s_r.tap == TAP_SH_IR) ? s_r.irSh[0] : s_r.drSh[0];
    end

    // Debug interrupt from the test input
    s_nxt.dint = 1'b0;
    if (!traceMode)
      s_nxt.rtActive = 1'b1;
    else if (s_r.rtActive && s_r.tdiSy[1])
    begin
      s_nxt.rtActive = 1'b0;
      s_nxt.dint = 1'b1;
    end
    // Level request while debug mode sees the pin low
    if (debugMode && !s_r.tdiSy[1])
      s_nxt.dint = 1'b1;

    // Trace capture clock, full or divided rate
    if (!trOn)
    begin
      s_nxt.tClk = 1'b0;
      s_nxt.divCnt = '0;
      s_nxt.busy = 1'b0;
      // Idle bit low, so a restarted trace never shows a stale bit
      s_nxt.tBit = 1'b0;
    end
    else if (s_r.divCnt == (traceDiv ? TC_HALF_DIV : TC_HALF_FULL))
    begin
      s_nxt.tClk = !s_r.tClk;
      s_nxt.divCnt = '0;
    end
    else
      s_nxt.divCnt = s_r.divCnt + 2'h1;

    // Program counter serialiser, bits change on the capture clock fall
    if (tcFall)
    begin
      s_nxt.status = debugMode ? TS_DEBUG : pcStatus;
      // Word in progress continues, lowest bit first
      if (s_r.busy)
      begin
        s_nxt.tBit = s_r.word[0];
        s_nxt.word = {1'b0, s_r.word[PC_W-1:1]};
        s_nxt.bitCnt = s_r.bitCnt - 5'h1;
        s_nxt.busy = s_r.bitCnt != 5'h1;
      end
      // Next buffered word; its stored status goes out with bit 0
      else if (fifoOutValid && !s_r.pop)
      begin
        s_nxt.tBit = fifoOut[0];
        s_nxt.word = {1'b0, fifoOut[PC_W-1:1]};
        s_nxt.bitCnt = PC_LAST_BIT;
        s_nxt.busy = 1'b1;
        s_nxt.pop = 1'b1;
        s_nxt.status = fifoOut[FIFO_W-1:PC_W];
      end
      else
        s_nxt.tBit = 1'b0;
    end
    else if (!trOn)
      s_nxt.status = debugMode ? TS_DEBUG : TS_SEQ;

    // Pin drive: trace word while trace mode runs, else shifted register
    s_nxt.tdo = trOn ? s_nxt.tBit : s_nxt.jtdo;
    s_nxt.oe = trOn || s_nxt.joe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_r <= s_nxt;
      // Synchronisers idle low
      s_r.tckSy <= SYNC_RESET;
      s_r.tmsSy <= SYNC_RESET;
      s_r.tdiSy <= SYNC_RESET;
      s_r.trstSy <= SYNC_RESET;
      s_r.tckPrev <= 1'b0;
      // Controller in test-logic-reset with the identity path
      s_r.tap <= TAP_RESET;
      s_r.ir <= IR_IDCODE;
      s_r.irSh <= IR_CAPTURE;
      s_r.drSh <= DR_RESET;
      s_r.jtdo <= 1'b0;
      s_r.joe <= 1'b0;
      // Trace path idle and armed
      s_r.divCnt <= '0;
      s_r.tClk <= 1'b0;
      s_r.word <= '0;
      s_r.bitCnt <= '0;
      s_r.busy <= 1'b0;
      s_r.tBit <= 1'b0;
      s_r.pop <= 1'b0;
      s_r.status <= TS_SEQ;
      s_r.rtActive <= 1'b1;
      s_r.dint <= 1'b0;
      s_r.tdo <= 1'b0;
      s_r.oe <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer of non-sequential program counter words
  jdt_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData({pcStatus, pcData}),
    .outValid(fifoOutValid),
    .outReady(s_r.pop),
    .outData(fifoOut)
  );

  // Pin outputs from flip-flops
  assign tdoOut = s_r.tdo;
  assign tdoOe = s_r.oe;

  // Buffer flag and trace outputs, also from flip-flops
  assign pcReady = fifoInReady;
  assign traceClk = s_r.tClk;
  assign traceStatus = s_r.status;
  assign traceRunning = s_r.rtActive;
  assign dbgIntReq = s_r.dint;
endmodule
`default_nettype wire

// [bench/jdt_port_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module jdt_port_assertions
  import jdt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tckPin,
  input wire logic tdiPin,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic traceMode,
  input wire logic debugMode,
  input wire logic traceDiv,
  input wire logic traceClk,
  input wire logic [2:0] traceStatus,
  input wire logic traceRunning,
  input wire logic dbgIntReq
);
  // One clock domain, reset disables every check
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Scan path alone, and a held debug interrupt in trace mode
  sequence jtagOnly;
    !traceMode ##1 !traceMode ##1 !traceMode;
  endsequence
  sequence tdiHeld;
    (traceMode && tdiPin)[*5];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  tdo_fall_a: assert property (jtagOnly ##0 $changed(tdoOut) |-> !tckPin)
    else $error("test output moved with test clock high");
  oe_fall_a: assert property (jtagOnly ##0 $changed(tdoOe) |-> !tckPin)
    else $error("output enable moved with test clock high");
  trace_oe_a: assert property (
    traceMode[*2] ##1 (traceMode && traceRunning) |-> tdoOe) else $error("trace not driven");
  tclk_fast_a: assert property ($rose(traceClk) && !traceDiv |=> !traceClk)
    else $error("capture clock high too long");
  tclk_slow_a: assert property ($rose(traceClk) && traceDiv |=> traceClk ##1 !traceClk)
    else $error("divided capture clock wrong");
  trace_stop_a: assert property (tdiHeld |-> !traceRunning)
    else $error("trace not stopped");
  dbg_pulse_a: assert property ($rose(dbgIntReq) && !debugMode |=> !dbgIntReq)
    else $error("stop request not one cycle");
  dbg_level_a: assert property ((debugMode && !tdiPin)[*5] |-> dbgIntReq)
    else $error("debug interrupt missing");
  ts_idle_a: assert property ((!traceMode && !debugMode)[*2] |-> traceStatus == TS_SEQ)
    else $error("idle status wrong");
  trace_idle_a: assert property (!traceMode ##1 traceMode |=> !tdoOut)
    else $error("stale bit on trace entry");
endmodule

bind jdt_port jdt_port_assertions i_chk (.clk(clk), .rstn(rstn), .tckPin(tckPin),
  .tdiPin(tdiPin), .tdoOut(tdoOut), .tdoOe(tdoOe), .traceMode(traceMode),
  .debugMode(debugMode), .traceDiv(traceDiv), .traceClk(traceClk),
  .traceStatus(traceStatus), .traceRunning(traceRunning), .dbgIntReq(dbgIntReq));
`default_nettype wire

// [bench/jdt_probe.sv]
`timescale 1ns/10ps
`default_nettype none
module jdt_probe
  import jdt_pkg::*;
#(
  parameter int HALF = 6
)
(
  input wire logic clk,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic traceClk,
  input wire logic [2:0] traceStatus,
  output logic tckPin,
  output logic tmsPin,
  output logic tdiPin,
  output logic trstPinN
);
  logic [PC_W-1:0] shiftWord;
  logic [2:0] firstSt;
  int nBits = 0;
  logic [FIFO_W-1:0] gotQ[$];

  // Unused link: reset low, clock pulled down, select and data pulled up
  initial
  begin
    tckPin = 1'b0;
    tmsPin = 1'b1;
    tdiPin = 1'b1;
    trstPinN = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One test clock period; output sampled late in the low half
  task automatic step(input logic m, input logic d, output logic o, output logic e);
    tmsPin = m;
    tdiPin = d;
    repeat (HALF) @(negedge clk);
    o = tdoOut;
    e = tdoOe;
    tckPin = 1'b1;
    repeat (HALF) @(negedge clk);
    tckPin = 1'b0;
  endtask

  // Run of mode select bits, first bit lowest
  task automatic walk(input logic [3:0] tms, input int n);
    logic o, e;
    for (int i = 0; i < n; i++)
      step(tms[i], 1'b1, o, e);
  endtask

  // Pulse of the test reset with the test clock still
  task automatic testReset();
    trstPinN = 1'b0;
    repeat (5) @(negedge clk);
    trstPinN = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // Capture trace words; a word starts at the first high bit
  always @(posedge traceClk)
  begin
    if (nBits == 0)
      firstSt = traceStatus;
    if (nBits > 0 || tdoOut === 1'b1)
      nBits++;
    shiftWord = {tdoOut, shiftWord[31:1]};
    if (nBits == 32)
    begin
      gotQ.push_back({firstSt, shiftWord});
      nBits = 0;
    end
  end
endmodule
`default_nettype wire

// [bench/jdt_port_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module jdt_port_bench;
  import jdt_pkg::*;
  localparam logic [31:0] ID = 32'h5a3c_0f01; // Arbitrary identity value
  logic clk, rstn, tckPin, tmsPin, tdiPin, trstPinN, tdoOut, tdoOe, traceMode, debugMode;
  logic traceDiv, pcValid, pcReady, traceClk, traceRunning, dbgIntReq, refused;
  logic [PC_W-1:0] pcData = '0;
  logic [2:0] pcStatus = TS_SEQ;
  logic [2:0] traceStatus;
  logic [FIFO_W-1:0] expQ[$];
  int failures = 0;
  int checksDone = 0;

  jdt_port #(.ID_CODE(ID)) i_dut (.clk(clk), .rstn(rstn), .tckPin(tckPin), .tmsPin(tmsPin),
    .tdiPin(tdiPin), .trstPinN(trstPinN), .tdoOut(tdoOut), .tdoOe(tdoOe), .traceMode(traceMode),
    .debugMode(debugMode), .traceDiv(traceDiv), .pcValid(pcValid), .pcData(pcData),
    .pcStatus(pcStatus), .pcReady(pcReady), .traceClk(traceClk), .traceStatus(traceStatus),
    .traceRunning(traceRunning), .dbgIntReq(dbgIntReq));
  jdt_probe i_probe (.clk(clk), .tdoOut(tdoOut), .tdoOe(tdoOe), .traceClk(traceClk),
    .traceStatus(traceStatus), .tckPin(tckPin), .tmsPin(tmsPin), .tdiPin(tdiPin),
    .trstPinN(trstPinN));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  // Mismatch count and report shared by the compare tasks
  task automatic miss(input logic [FIFO_W-1:0] got, input logic [FIFO_W-1:0] exp);
    failures++;
    $display("unexpected at %0t: got %h expected %h", $time, got, exp);
  endtask
  // Scan pin pair: output enable and data
  task automatic cmpScan(input logic [1:0] got, input logic [1:0] exp);
    checksDone++;
    if (got !== exp)
      miss(35'(got), 35'(exp));
  endtask
  // Status flags and codes
  task automatic cmpFlag(input logic [3:0] got, input logic [3:0] exp);
    checksDone++;
    if (got !== exp)
      miss(35'(got), 35'(exp));
  endtask
  // Trace word with its status
  task automatic cmpWord(input logic [FIFO_W-1:0] got, input logic [FIFO_W-1:0] exp);
    checksDone++;
    if (got !== exp)
      miss(got, exp);
  endtask
  // Verdict
  task automatic tally_and_finish();
    if (failures == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Expected bit k of a data scan: identity, or input delayed by one
  function automatic logic drBit(input logic [3:0] ir, input int k, input logic [31:0] din);
    if (ir == IR_IDCODE)
      return ID[k];
    return (k == 0) ? 1'b0 : din[k-1];
  endfunction

  // Data scan from idle with random input, back to idle
  task automatic drCheck(input logic [3:0] ir);
    logic o, e;
    logic [31:0] din;
    din = $urandom;
    i_probe.walk(4'b0001, 3);
    for (int k = 0; k < DR_LEN; k++)
    begin
      i_probe.step(k == DR_LEN - 1, din[k], o, e);
      cmpScan({e, o}, {1'b1, drBit(ir, k, din)});
    end
    i_probe.step(1'b1, 1'b1, o, e);
    cmpFlag(4'(e), 4'h0);
    i_probe.walk(4'b0000, 1);
  endtask

  // Offer a trace word and hold it until taken
  task automatic push(input logic [2:0] st);
    pcValid = 1'b1;
    pcStatus = st;
    pcData = $urandom | 32'h1;
    while (pcReady !== 1'b1)
    begin
      refused = 1'b1;
      @(negedge clk);
    end
    if (st == TS_JUMP_PC || st == TS_EXCEPT)
      expQ.push_back({st, pcData});
    @(negedge clk);
  endtask

  // Wait until every word is out, then leave trace mode in a low phase
  task automatic drain();
    pcValid = 1'b0;
    pcStatus = TS_SEQ;
    while (i_probe.gotQ.size() < expQ.size())
      @(negedge clk);
    @(negedge clk iff traceClk === 1'b0);
    traceMode = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scan path, trace path, then debug interrupt
  initial
  begin
    logic [3:0] ir;
    logic o, e;
    {rstn, traceMode, debugMode, traceDiv, pcValid, refused} = '0;
    void'($urandom(34));
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 6; i++)
    begin
      i_probe.testReset();
      i_probe.walk(4'b0000, 1);
      drCheck(IR_IDCODE);
      ir = (i == 0) ? IR_BYPASS : 4'($urandom);
      i_probe.walk(4'b0011, 4);
      for (int k = 0; k < IR_LEN; k++)
      begin
        i_probe.step(k == IR_LEN - 1, ir[k], o, e);
        cmpScan({e, o}, {1'b1, IR_CAPTURE[k]});
      end
      i_probe.walk(4'b0001, 2);
      drCheck(ir);
    end
    i_probe.tdiPin = 1'b0;
    repeat (4) @(negedge clk);
    traceDiv = 1'b1;
    traceMode = 1'b1;
    for (int i = 0; i < 12; i++)
      push(i[0] ? TS_JUMP_PC : TS_EXCEPT);
    cmpFlag(4'(refused), 4'h1);
    drain();
    traceDiv = 1'b0;
    repeat (4) @(negedge clk);
    traceMode = 1'b1;
    for (int i = 0; i < 24; i++)
      push(i < 8 ? 3'(i) : 3'($urandom));
    drain();
    foreach (expQ[k])
      cmpWord(i_probe.gotQ[k], expQ[k]);
    traceMode = 1'b1;
    repeat (4) @(negedge clk);
    i_probe.tdiPin = 1'b1;
    repeat (6) @(negedge clk);
    cmpFlag(4'({traceRunning, traceClk}), 4'h0);
    traceMode = 1'b0;
    repeat (4) @(negedge clk);
    cmpFlag(4'(traceRunning), 4'h1);
    debugMode = 1'b1;
    i_probe.tdiPin = 1'b0;
    repeat (6) @(negedge clk);
    cmpFlag({dbgIntReq, traceStatus}, {1'b1, TS_DEBUG});
    tally_and_finish();
  end
endmodule
`default_nettype wire
